// [expbt_defines.vh]
// expansion bus phase timing: shared constants
// assumes inclusion by bare name from the design files
`ifndef EXPBT_DEFINES_VH
`define EXPBT_DEFINES_VH
// phase settings are 4-bit codes; code n means n+1 bus clock cycles
`define EXPBT_LEN_W 4
// address phase and ale pulse limited to 1..4 cycles (2-bit code)
`define EXPBT_SHORT_W 2
`define EXPBT_ADDR_W 24
`define EXPBT_DATA_W 16
// clock period in ns, for reference by timing checks
`define EXPBT_CLK_NS 20
`endif

// [expbt_phase_counter.v]
// expansion bus phase timing: per-phase down counter
// assumes a single clk with synchronous active-high reset
`timescale 1ns/1ps
`include "expbt_defines.vh"
module expbt_phase_counter (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// control
	input wire load,
	input wire [`EXPBT_LEN_W-1:0] loadValue,
	input wire busTick,
	// status
	output wire expired
);
	reg [`EXPBT_LEN_W-1:0] count;

	////////////////////////////////////////////////////////////
	// count whole bus clock periods only
	always @(posedge clk) begin
		if (sys_rst) begin
			count <= {`EXPBT_LEN_W{1'b0}};
		end else if (load) begin
			count <= loadValue;
		end else if (busTick && count != {`EXPBT_LEN_W{1'b0}}) begin
			count <= count - 4'h1;
		end
	end

	assign expired = busTick && (count == {`EXPBT_LEN_W{1'b0}});
endmodule // expbt_phase_counter

// [expbt_phase_timing.v]
// expansion bus phase timing: access sequencer driving strobes and one chip select
// assumes synchronous inputs, single clk, busTick as one-cycle bus clock enable
// integration notes:
// a request is taken only on a busTick cycle while the sequencer is idle
// pins are registered from next_state, so every pin edge lines up with a
// phase change and shows no decode glitch; the trade is one flop per pin
// chip select opens on the edge that ends the latch strobe, so the
// peripheral first samples it one bus clock after the fall
// phase codes are levels and are read when each phase starts; changing
// them in mid-access only affects phases that have not yet begun
`timescale 1ns/1ps
`include "expbt_defines.vh"
module expbt_phase_timing (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	input wire busTick,
	// configuration
	input wire multiplexMode,
	input wire [`EXPBT_SHORT_W-1:0] address_phase_len,
	input wire [`EXPBT_LEN_W-1:0] setup_phase_len,
	input wire [`EXPBT_LEN_W-1:0] strobe_phase_len,
	input wire [`EXPBT_LEN_W-1:0] hold_phase_len,
	input wire [`EXPBT_LEN_W-1:0] recovery_phase_len,
	// request side
	input wire reqValid,
	input wire reqWrite,
	input wire [`EXPBT_ADDR_W-1:0] reqAddr,
	input wire [`EXPBT_DATA_W-1:0] reqWrData,
	output wire reqReady,
	output reg accessDone,
	output reg [`EXPBT_DATA_W-1:0] rdData,
	// expansion bus pins
	output reg addr_latch_strobe,
	output reg chipSelect_n,
	output reg read_strobe_n,
	output reg write_strobe_n,
	output reg [`EXPBT_ADDR_W-1:0] busAddr,
	output reg [`EXPBT_DATA_W-1:0] busDataOut,
	output reg busDataOe,
	input wire [`EXPBT_DATA_W-1:0] busDataIn
);
	// one-hot phase states
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_SETUP = 6'h04;
	localparam [5:0] ST_STROBE = 6'h08;
	localparam [5:0] ST_HOLD = 6'h10;
	localparam [5:0] ST_RECOV = 6'h20;

	reg [5:0] state;
	reg [5:0] next_state;
	reg isWrite;
	reg [`EXPBT_LEN_W-1:0] loadValue;
	reg load;
	wire expired;

	////////////////////////////////////////////////////////////
	// phase length counter
	expbt_phase_counter phaseCounter (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(load),
		.loadValue(loadValue),
		.busTick(busTick),
		.expired(expired)
	);

	////////////////////////////////////////////////////////////
	// ready only on a tick so a request never starts mid bus cycle
	assign reqReady = state[0] && busTick;

	////////////////////////////////////////////////////////////
	// select window: setup, strobe and hold phases
	// shared by chip select and data enable so on writes both
	// open and close on the same edge; on reads data enable stays low
	function selWindow;
		input [5:0] st;
		begin
			selWindow = st[2] || st[3] || st[4];
		end
	endfunction

	////////////////////////////////////////////////////////////
	// fixed phase order; each step after idle waits for the counter
	always @* begin
		next_state = state;
		load = 1'b0;
		loadValue = {`EXPBT_LEN_W{1'b0}};
		case (state)
		ST_IDLE: begin
			if (reqValid && busTick) begin
				next_state = ST_ADDR;
				load = 1'b1;
				loadValue = {2'h0, address_phase_len};
			end
		end
		ST_ADDR: begin
			if (expired) begin
				next_state = ST_SETUP;
				load = 1'b1;
				loadValue = setup_phase_len;
			end
		end
		ST_SETUP: begin
			if (expired) begin
				next_state = ST_STROBE;
				load = 1'b1;
				loadValue = strobe_phase_len;
			end
		end
		ST_STROBE: begin
			if (expired) begin
				next_state = ST_HOLD;
				load = 1'b1;
				loadValue = hold_phase_len;
			end
		end
		ST_HOLD: begin
			if (expired) begin
				next_state = ST_RECOV;
				load = 1'b1;
				loadValue = recovery_phase_len;
			end
		end
		ST_RECOV: begin
			if (expired) begin
				next_state = ST_IDLE;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	////////////////////////////////////////////////////////////
	// state and captured request
	always @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			isWrite <= 1'b0;
			busAddr <= {`EXPBT_ADDR_W{1'b0}};
			busDataOut <= {`EXPBT_DATA_W{1'b0}};
		end else begin
			state <= next_state;
			if (state[0] && reqValid && busTick) begin
				isWrite <= reqWrite;
				busAddr <= reqAddr;
				busDataOut <= reqWrData;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// pins registered from the next state so they align with phases
	always @(posedge clk) begin
		if (sys_rst) begin
			addr_latch_strobe <= 1'b0;
			chipSelect_n <= 1'b1;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			busDataOe <= 1'b0;
		end else begin
			// ale only in multiplexed mode, high for whole address phase
			addr_latch_strobe <= multiplexMode && next_state[1];
			// cs opens on the same edge as the ale fall, with no cycle between
			chipSelect_n <= !selWindow(next_state);
			read_strobe_n <= !(next_state[3] && !(state[0] ? reqWrite : isWrite));
			write_strobe_n <= !(next_state[3] && isWrite);
			// write data held from setup through hold
			busDataOe <= isWrite && selWindow(next_state);
		end
	end

	////////////////////////////////////////////////////////////
	// read data sampled on the final strobe cycle
	// sampling late in the strobe gives the peripheral the
	// whole strobe phase to drive; a short strobe limits this
	// done pulse marks the end of hold, recovery still follows
	always @(posedge clk) begin
		if (sys_rst) begin
			rdData <= {`EXPBT_DATA_W{1'b0}};
			accessDone <= 1'b0;
		end else begin
			accessDone <= state[4] && expired;
			if (state[3] && expired && !isWrite) begin
				rdData <= busDataIn;
			end
		end
	end
endmodule // expbt_phase_timing

// [expbt_phase_timing_asserts.sv]
// checker: pin timing of the sequencer
// assumes busTick held high
`timescale 1ns/1ps
module expbt_phase_checker (input wire clk, sys_rst, multiplexMode, reqReady, accessDone, addr_latch_strobe,
	chipSelect_n, read_strobe_n, write_strobe_n, busDataOe);
	// short active-high views of the pins
	wire ale = addr_latch_strobe;
	wire cs = !chipSelect_n;
	wire wr = !write_strobe_n;
	wire rd = !read_strobe_n;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_smp; !multiplexMode |-> !ale; endproperty
	a_smp: assert property (p_smp) else $error("ale");
	property p_ale; $rose(ale) |-> ##[1:4] !ale; endproperty
	a_ale: assert property (p_ale) else $error("alew");
	property p_cs; $fell(ale) |-> ##[0:3] cs; endproperty
	a_cs: assert property (p_cs) else $error("cs");
	property p_wr; $rose(wr) |-> ##[1:16] !wr; endproperty
	a_wr: assert property (p_wr) else $error("wrw");
	property p_oe; wr |-> busDataOe && cs; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_su; $rose(wr) |-> $past(cs); endproperty
	a_su: assert property (p_su) else $error("setup");
	property p_hd; $fell(wr) || $fell(rd) |-> cs; endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_dn; accessDone |-> $fell(cs) && !reqReady; endproperty
	a_dn: assert property (p_dn) else $error("done");
endmodule // expbt_phase_checker
////////
bind expbt_phase_timing expbt_phase_checker chk (.*);

// [expbt_periph_model.sv]
// partner: peripheral answering reads, recording writes
// assumes the sequencer's pins
`timescale 1ns/1ps
module expbt_periph_model (input wire clk, chipSelect_n, read_strobe_n, write_strobe_n,
	input wire [23:0] busAddr, input wire [15:0] busDataOut, output wire [15:0] busDataIn, output reg [15:0] wrSeen);
	reg [15:0] last = 16'h0;
	// released bus inverts every cycle, so a sample one cycle late cannot match
	assign busDataIn = read_strobe_n | chipSelect_n ? ~last : busAddr[15:0] ^ 16'h5a5a;
	// keep the word seen under the write strobe
	always @(posedge clk) begin
		last <= busDataIn;
		if (!write_strobe_n) wrSeen <= busDataOut;
	end
endmodule // expbt_periph_model

// [expbt_phase_timing_bench.sv]
// bench: timed accesses in both bus modes
// assumes busTick tied high
`timescale 1ns/1ps
module expbt_phase_timing_bench;
	reg clk = 1'b0, sys_rst = 1'b1, busTick = 1'b1, multiplexMode = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
	reg [1:0] address_phase_len = 2'h0;
	reg [3:0] setup_phase_len = 4'h0, strobe_phase_len = 4'h0, hold_phase_len = 4'h0, recovery_phase_len = 4'h0;
	reg [23:0] reqAddr = 24'h0;
	reg [15:0] reqWrData = 16'h0;
	wire reqReady, accessDone, addr_latch_strobe, chipSelect_n, read_strobe_n, write_strobe_n, busDataOe;
	wire [23:0] busAddr;
	wire [15:0] rdData, busDataOut, busDataIn, wrSeen;
	integer n_mismatch = 0, tests_run = 0, cyc = 0, k, nA, nS;
	expbt_phase_timing uut (.*);
	expbt_periph_model peer (.*);
	////////
	// clock, and a guard against a hung handshake
	initial forever #10 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin n_mismatch++; summarize; end
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, e, g); end
	endtask
	// one access; pins counted at falling edges, once settled
	task access(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [1:0] ap,
		input logic [3:0] sp, tp, hp, rp);
		{address_phase_len, setup_phase_len, strobe_phase_len, hold_phase_len, recovery_phase_len} = {ap, sp, tp, hp, rp};
		{reqWrite, reqAddr, reqWrData, reqValid, k, nA, nS} = {w, a, d, 1'b1, 96'h0};
		while (reqReady !== 1'b1) @(negedge clk);
		@(negedge clk) reqValid = 1'b0;
		while (accessDone !== 1'b1) begin
			nA += addr_latch_strobe;
			nS += !(read_strobe_n && write_strobe_n);
			if (!(read_strobe_n && write_strobe_n)) chk("addr", {8'h0, a}, busAddr);
			if (!(read_strobe_n && write_strobe_n)) chk("oe", w, busDataOe);
			@(negedge clk) k++;
		end
		chk("cycles", ap + sp + tp + hp + 4, k);
		chk("ale", multiplexMode ? ap + 1 : 0, nA);
		chk("strobe", tp + 1, nS);
		chk("data", w ? d : a[15:0] ^ 16'h5a5a, w ? wrSeen : rdData);
		for (k = 0; reqReady !== 1'b1; k++) @(negedge clk);
		chk("recovery", rp + 1, k);
		$display("access at %0h done", a);
	endtask
	// reset, then edge phase codes in multiplexed mode and mixed codes in non-multiplexed mode
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		access(1'b1, 24'h00a5c3, 16'h1234, 2'h0, 4'h0, 4'h0, 4'h0, 4'h0);
		access(1'b0, 24'h0f0f0f, 16'h0000, 2'h3, 4'hf, 4'hf, 4'hf, 4'hf);
		multiplexMode = 1'b0;
		access(1'b1, 24'h123456, 16'hbeef, 2'h2, 4'h1, 4'h3, 4'h4, 4'h9);
		summarize;
	end
endmodule // expbt_phase_timing_bench
